// ---- core/twc_consts.svh ----
// Constants for the timer and watchdog counter block
`ifndef TWC_CONSTS_SVH
`define TWC_CONSTS_SVH
`define TWC_AW 8
`define TWC_CTRL_OFF 8'h00
`define TWC_LOW_OFF 8'h04
`define TWC_HIGH_OFF 8'h08
`define TWC_PRESC_OFF 8'h0C
`define TWC_WDCFG_OFF 8'h10
`define TWC_CTRL_RST 8'h12
`define TWC_CONST_RST 8'hFF
`define TWC_PRESC_RST 8'hFF
`define TWC_KEY_ONE 8'hAA
`define TWC_KEY_TWO 8'h55
`define TWC_RESP_OKAY 2'h0
`define TWC_RESP_SLVERR 2'h2
`define TWC_DIV_LAST 2'h3
`endif

// ---- core/twc_pkg.sv ----
// Types shared by the timer and watchdog counter block
`include "twc_consts.svh"
package twc_pkg;
   typedef enum logic [1:0] {
      TWC_IN_EVENT = 2'h0,
      TWC_IN_GATED = 2'h1,
      TWC_IN_TRIG = 2'h2,
      TWC_IN_RETRIG = 2'h3
   } twc_inmode_t;
   typedef struct packed {
      logic run;
      logic single;
      twc_inmode_t inmode;
      logic in_en;
      logic out_mode;
      logic out_level;
      logic out_en;
   } twc_ctrl_t;
   typedef struct packed {
      logic awvalid;
      logic [`TWC_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`TWC_AW-1:0] araddr;
      logic rready;
   } twc_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } twc_axi_rsp_t;
   typedef struct packed {
      twc_ctrl_t ctrl;
      logic [7:0] const_lo;
      logic [7:0] const_hi;
      logic [7:0] presc;
      logic [15:0] cnt;
      logic [7:0] psc;
      logic [1:0] div4;
      logic const_new;
      logic was_run;
      logic armed;
      logic wd_en;
      logic a0_sel;
      logic key_seen;
      logic wave;
      logic pin;
      logic in_s1;
      logic in_s2;
      logic in_s3;
      logic irq_s1;
      logic irq_s2;
      logic irq_top;
      logic irq_a0;
      logic sys_rst;
      logic aw_got;
      logic w_got;
      logic [`TWC_AW-1:0] awaddr;
      logic [7:0] wbyte;
      logic wlane;
      twc_axi_rsp_t axi;
   } twc_state_t;
endpackage

// ---- core/twc_timer.sv ----
// Timer, event counter and watchdog with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "twc_consts.svh"
module twc_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire twc_pkg::twc_axi_req_t axi_req,
   output var twc_pkg::twc_axi_rsp_t axi_rsp,
   // Pins
   input wire logic count_input_pin,
   input wire logic ext_irq_input_zero,
   output logic waveform_output_pin,
   // Interrupt and reset requests
   output logic eoc_irq_top,
   output logic eoc_irq_a0,
   output logic sys_reset_req
);
   import twc_pkg::*;

   twc_state_t s;
   twc_state_t next_s;
   logic run;
   logic fall;
   logic q4;
   logic ext;
   logic tick;
   logic step;
   logic eoc;
   logic wr_go;
   logic rd_go;
   logic wr_ctrl;
   logic [15:0] const_full;

   // Byte lane 0 carries all eight-bit registers
   function automatic logic [7:0] rd_mux(input logic [`TWC_AW-1:0] a,
                                         input twc_state_t st);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `TWC_CTRL_OFF: v = st.ctrl;
         `TWC_LOW_OFF: v = st.cnt[7:0];
         `TWC_HIGH_OFF: v = st.cnt[15:8];
         `TWC_PRESC_OFF: v = st.presc;
         `TWC_WDCFG_OFF: v = {6'h00, st.a0_sel, st.wd_en};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [`TWC_AW-1:0] a);
      return a == `TWC_CTRL_OFF || a == `TWC_LOW_OFF ||
             a == `TWC_HIGH_OFF || a == `TWC_PRESC_OFF ||
             a == `TWC_WDCFG_OFF;
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      const_full = {s.const_hi, s.const_lo};
      // two-stage sync, edge from synced stages
      next_s.in_s1 = count_input_pin;
      next_s.in_s2 = s.in_s1;
      next_s.in_s3 = s.in_s2;
      next_s.irq_s1 = ext_irq_input_zero;
      next_s.irq_s2 = s.irq_s1;
      fall = s.in_s3 & ~s.in_s2;
      // free divider gives the clock/4 tick
      next_s.div4 = s.div4 + 2'h1;
      q4 = s.div4 == `TWC_DIV_LAST;
      run = s.wd_en | s.ctrl.run;
      ext = s.ctrl.in_en & ~s.wd_en;
      next_s.was_run = run;
      // arm on first edge after run set
      if (!run) begin
         next_s.armed = 1'b0;
      end else if (ext && s.ctrl.inmode == TWC_IN_TRIG && fall) begin
         next_s.armed = 1'b1;
      end
      // pick count source from input mode
      tick = 1'b0;
      if (!ext) begin
         tick = q4;
      end else begin
         unique case (s.ctrl.inmode)
            // each synced falling edge is one count
            TWC_IN_EVENT: tick = fall;
            TWC_IN_GATED: tick = q4 & s.in_s2;
            TWC_IN_TRIG: tick = q4 & s.armed;
            TWC_IN_RETRIG: tick = q4;
         endcase
      end
      tick = tick & run;
      // prescaler wrap every value plus one ticks
      step = tick && s.psc == 8'h00;
      eoc = step && s.cnt == 16'h0000;
      next_s.irq_top = 1'b0;
      next_s.irq_a0 = s.irq_s2;
      next_s.sys_rst = 1'b0;
      if (tick) begin
         next_s.psc = step ? s.presc : s.psc - 8'h01;
      end
      if (step) begin
         next_s.cnt = s.cnt - 16'h0001;
      end
      if (eoc) begin
         next_s.cnt = const_full;
         next_s.const_new = 1'b0;
         // single run stops and clears run bit
         if (s.ctrl.single && !s.wd_en) begin
            next_s.ctrl.run = 1'b0;
         end
         if (s.wd_en) begin
            next_s.sys_rst = 1'b1;
         end else if (s.a0_sel) begin
            // timer end is ORed with the external A0 source
            next_s.irq_a0 = 1'b1;
         end else begin
            next_s.irq_top = 1'b1;
         end
         // square wave toggles at each end
         next_s.wave = s.ctrl.out_mode ? s.ctrl.out_level : ~s.wave;
      end
      // halted constant change loads at restart
      if (run && !s.was_run && s.const_new) begin
         next_s.cnt = const_full;
         next_s.psc = s.presc;
         next_s.const_new = 1'b0;
      end
      if (run && ext && s.ctrl.inmode == TWC_IN_RETRIG && fall) begin
         next_s.cnt = const_full;
         next_s.psc = s.presc;
         next_s.const_new = 1'b0;
      end

      // AXI write channel: address and data in either order
      if (axi_req.awvalid && s.axi.awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s.axi.wready) begin
         next_s.w_got = 1'b1;
         next_s.wbyte = axi_req.wdata[7:0];
         next_s.wlane = axi_req.wstrb[0];
      end
      wr_go = s.aw_got && s.w_got && !s.axi.bvalid;
      wr_ctrl = wr_go && s.wlane && s.awaddr == `TWC_CTRL_OFF;
      if (wr_go) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.axi.bvalid = 1'b1;
         next_s.axi.bresp = mapped(s.awaddr) ? `TWC_RESP_OKAY
                                             : `TWC_RESP_SLVERR;
         if (s.wlane) begin
            unique case (s.awaddr)
               // software write wins over hardware clear
               // single bit and run bit in one write
               `TWC_CTRL_OFF: next_s.ctrl = s.wbyte;
               `TWC_LOW_OFF: begin
                  if (s.wd_en) begin
                     if (s.key_seen && s.wbyte == `TWC_KEY_TWO) begin
                        next_s.cnt = const_full;
                        next_s.psc = s.presc;
                     end
                     next_s.key_seen = s.wbyte == `TWC_KEY_ONE;
                  end else begin
                     next_s.const_lo = s.wbyte;
                     next_s.const_new = 1'b1;
                  end
               end
               `TWC_HIGH_OFF: begin
                  if (!s.wd_en) begin
                     next_s.const_hi = s.wbyte;
                     next_s.const_new = 1'b1;
                  end
               end
               `TWC_PRESC_OFF: begin
                  next_s.presc = s.wbyte;
                  next_s.psc = s.wbyte;
               end
               // Watchdog enable cannot be withdrawn once set
               `TWC_WDCFG_OFF: begin
                  next_s.wd_en = s.wd_en | s.wbyte[0];
                  next_s.a0_sel = s.wbyte[1];
               end
               default: next_s.ctrl = s.ctrl;
            endcase
         end
      end
      if (s.axi.bvalid && axi_req.bready) begin
         next_s.axi.bvalid = 1'b0;
      end
      next_s.axi.awready = !next_s.aw_got && !next_s.axi.bvalid;
      next_s.axi.wready = !next_s.w_got && !next_s.axi.bvalid;

      // AXI read channel: one read at a time
      rd_go = axi_req.arvalid && s.axi.arready;
      if (rd_go) begin
         next_s.axi.rvalid = 1'b1;
         next_s.axi.rdata = {24'h000000, rd_mux(axi_req.araddr, s)};
         next_s.axi.rresp = mapped(axi_req.araddr) ? `TWC_RESP_OKAY
                                                   : `TWC_RESP_SLVERR;
      end
      if (s.axi.rvalid && axi_req.rready) begin
         next_s.axi.rvalid = 1'b0;
      end
      next_s.axi.arready = !next_s.axi.rvalid;

      // disabled output sits high for pin sharing
      next_s.pin = next_s.ctrl.out_en ? next_s.wave : 1'b1;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // whole counter state lives here
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= `TWC_CTRL_RST;
         s.const_lo <= `TWC_CONST_RST;
         s.const_hi <= `TWC_CONST_RST;
         s.presc <= `TWC_PRESC_RST;
         s.psc <= `TWC_PRESC_RST;
         s.cnt <= {`TWC_CONST_RST, `TWC_CONST_RST};
         s.pin <= 1'b1;
         s.wave <= 1'b1;
         s.in_s1 <= 1'b1;
         s.in_s2 <= 1'b1;
         s.in_s3 <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flops
   assign axi_rsp = s.axi;
   assign waveform_output_pin = s.pin;
   assign eoc_irq_top = s.irq_top;
   assign eoc_irq_a0 = s.irq_a0;
   assign sys_reset_req = s.sys_rst;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_pin_idle_high: assert property (
      !s.ctrl.out_en |-> waveform_output_pin)
      else $error("output not high while disabled");
   chk_eoc_reload: assert property (
      eoc && !wr_go |=> s.cnt == $past(const_full))
      else $error("constant not reloaded at end of count");
   chk_single_stop: assert property (
      eoc && s.ctrl.single && !s.wd_en && !wr_ctrl |=> !s.ctrl.run)
      else $error("single mode did not clear run");
   chk_halt_holds: assert property (
      !run && !wr_go |=> s.cnt == $past(s.cnt) [*1])
      else $error("counter moved while halted");
   chk_square_toggle: assert property (
      eoc && !s.ctrl.out_mode |=> s.wave != $past(s.wave))
      else $error("square wave did not toggle");
   chk_pwm_copy: assert property (
      eoc && s.ctrl.out_mode |=> s.wave == $past(s.ctrl.out_level))
      else $error("pwm level not copied");
   chk_wd_reset: assert property (
      eoc && s.wd_en |=> sys_reset_req ##1 !sys_reset_req)
      else $error("watchdog reset pulse wrong");
   chk_irq_top: assert property (
      eoc && !s.wd_en && !s.a0_sel |=> eoc_irq_top && !sys_reset_req)
      else $error("timer interrupt missing");
   chk_retrig_load: assert property (
      run && ext && s.ctrl.inmode == TWC_IN_RETRIG && fall && !wr_go
      |=> s.cnt == $past(const_full))
      else $error("retrigger did not reload");
endmodule
`default_nettype wire

// ---- dv/twc_pin_src.sv ----
// Partner model that drives the external count pin
`timescale 1ns/1ps
`default_nettype none
module twc_pin_src (
   // Clock
   input wire logic clk,
   // Pin towards the block
   output logic count_input_pin
);
   // ------------------------------
   // Edge generator
   // ------------------------------
   // Pin idles high between events
   initial begin
      count_input_pin = 1'b1;
   end
   task automatic edges(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clk);
         count_input_pin <= 1'b0;
         repeat (4) @(posedge clk);
         count_input_pin <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench for the timer and watchdog counter
`timescale 1ns/1ps
`default_nettype none
module tb;
   import twc_pkg::*;
   logic clk, rst, pin, wave, top, a0, sres;
   twc_axi_req_t req;
   twc_axi_rsp_t rsp;
   int miscompares, n_tests, n_top, n_rst, n_a0;
   logic [31:0] d;
   logic [1:0] r;
   logic p0;
   // ------------------------------
   // Design and partner
   // ------------------------------
   twc_timer u_twc_timer (.clk(clk), .rst(rst), .axi_req(req),
      .axi_rsp(rsp), .count_input_pin(pin), .ext_irq_input_zero(1'b0),
      .waveform_output_pin(wave), .eoc_irq_top(top), .eoc_irq_a0(a0),
      .sys_reset_req(sres));
   twc_pin_src u_twc_pin_src (.clk(clk), .count_input_pin(pin));
   // Clock at 100 MHz
   always #5 clk = ~clk;
   // Pulse counters, outputs stand one cycle
   always @(posedge clk) begin
      if (top === 1'b1) n_top++;
      if (sres === 1'b1) n_rst++;
      if (a0 === 1'b1) n_a0++;
   end
   // ------------------------------
   // Helpers
   // ------------------------------
   task final_report;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Hang guard shared by all waits
   task automatic bail(input string nm);
      miscompares++;
      $display("Error %s exp done seen timeout", nm);
      final_report;
   endtask
   // Write; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int i;
      @(posedge clk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= {24'h000000, v};
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'b0;
      if (i == 50) bail("write");
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
      if (i == 50) bail("read");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("rdata", d, e);
   endtask
   task automatic wait_cnt(ref int c, input int tgt, input int lim);
      int i;
      for (i = 0; i < lim && c < tgt; i++) @(posedge clk);
      if (c < tgt) bail("pulse");
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset;
      chk("pin", {31'h0, wave}, 32'h00000001);
      rchk(8'h00, 32'h00000012);
      rchk(8'h04, 32'h000000FF);
      rchk(8'h08, 32'h000000FF);
      rchk(8'h0C, 32'h000000FF);
      rd(8'h14);
      chk("resp", {30'h0, r}, 32'h00000002);
      $display("test reset done");
   endtask
   task automatic t_single;
      wr(8'h04, 8'h03);
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h00, 8'hC1);
      repeat (2) @(posedge clk);
      p0 = wave;
      wait_cnt(n_top, 1, 300);
      repeat (3) @(posedge clk);
      chk("square", {31'h0, wave}, {31'h0, ~p0});
      rchk(8'h00, 32'h00000041);
      rchk(8'h04, 32'h00000003);
      $display("test single done");
   endtask
   task automatic t_event;
      wr(8'h04, 8'h02);
      // Level bit 1 so the copy differs from the old square-wave level
      wr(8'h00, 8'hCF);
      u_twc_pin_src.edges(2);
      chk("irq", n_top, 1);
      rchk(8'h04, 32'h00000000);
      u_twc_pin_src.edges(1);
      wait_cnt(n_top, 2, 100);
      repeat (3) @(posedge clk);
      chk("pwm", {31'h0, wave}, 32'h00000001);
      rchk(8'h00, 32'h0000004F);
      $display("test event done");
   endtask
   task automatic t_trig;
      // Timer end routed to channel A0
      wr(8'h10, 8'h02);
      wr(8'h04, 8'h01);
      wr(8'h00, 8'hE9);
      repeat (40) @(posedge clk);
      rchk(8'h04, 32'h00000001);
      chk("a0 idle", n_a0, 0);
      u_twc_pin_src.edges(1);
      wait_cnt(n_a0, 1, 100);
      chk("a0", n_a0, 1);
      chk("top a0", n_top, 2);
      wr(8'h10, 8'h00);
      $display("test trigger done");
   endtask
   task automatic t_wdog;
      int k;
      wr(8'h04, 8'h03);
      wr(8'h00, 8'h00);
      wr(8'h10, 8'h01);
      wait_cnt(n_rst, 1, 300);
      chk("top", n_top, 2);
      k = n_rst;
      repeat (8) begin
         wr(8'h04, 8'hAA);
         wr(8'h04, 8'h55);
      end
      chk("kick", n_rst, k);
      wait_cnt(n_rst, k + 1, 300);
      $display("test watchdog done");
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      req = '0;
      req.wstrb = 4'hF;
      miscompares = 0;
      n_tests = 0;
      n_top = 0;
      n_rst = 0;
      n_a0 = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_single;
      t_event;
      t_trig;
      t_wdog;
      final_report;
   end
endmodule
`default_nettype wire
